// ===== include/bdalu_regs.vh
// constants for the binary/decimal alu with feeder registers
// Contract
// - two 16-bit feeder registers of two 8-bit halves, chained for shifting
// - four feeder actions by two mode lines: right, left, load, hold
// - a feeder loads from the bus when named as destination
// - one-bit shifts move the 32-bit a:b chain, end-off
// - registers change at cycle end; shifted copy goes to destination meanwhile
// - three inserts merge a nybble or byte of a into b word
// - pass ops route a or b unmodified to the destination
// - invert drives ones' complement of a onto the bus
// - bit tests read one bit of a into condition bit zero
// - bit index from dest field low 4 bits or b low 4 bits
// - bit test suppresses destination decoding for its whole instruction
// - six binary add/subtract ops on 16-bit two's-complement operands with carry, overflow
// - binary carries kept in condition register for multiple precision
// - decimal ops use low bytes as two packed bcd digits, byte result
// - carry out of high decimal digit saved in condition register
// - decimal subtract is ten's complement add; no carry leaves negative result
// - first-pass decimal ops ignore stored carry but store new carry
// - extended decimal ops use stored carry and store new carry
// - decimal adder runs beside binary alu, corrects digit sums over nine
// - decimal subtract nine's-complements one input; the first-pass form forces low carry in
// - xor, or, and computed in binary alu, chosen only by 5-bit op
// - compare does signed and unsigned compare together, both into condition register
// - binary ops take one micro-cycle, decimal ops take two
// - bus drivers enabled only for alu formats that carry a destination
`ifndef BDALU_REGS_VH
`define BDALU_REGS_VH
// feeder mode codes
`define BDALU_MODE_HOLD   2'h0
`define BDALU_MODE_RIGHT  2'h1
`define BDALU_MODE_LEFT   2'h2
`define BDALU_MODE_LOAD   2'h3
// alu op codes (5 bits)
`define BDALU_OP_PASS_A   5'h00
`define BDALU_OP_PASS_B   5'h01
`define BDALU_OP_SHR      5'h02
`define BDALU_OP_SHL      5'h03
`define BDALU_OP_INS1     5'h04
`define BDALU_OP_INS2     5'h05
`define BDALU_OP_INSB     5'h06
`define BDALU_OP_INV      5'h07
`define BDALU_OP_BT_REG   5'h08
`define BDALU_OP_BT_FLD   5'h09
`define BDALU_OP_ADD      5'h0a
`define BDALU_OP_BAD      5'h0b
`define BDALU_OP_BINARY_ADD_WITH_CARRY     5'h0c
`define BDALU_OP_SUB      5'h0d
`define BDALU_OP_BSB      5'h0e
`define BDALU_OP_BINARY_SUBTRACT_WITH_BORROW     5'h0f
`define BDALU_OP_DAD      5'h10
`define BDALU_OP_DECIMAL_ADD_EXTENDED     5'h11
`define BDALU_OP_DSB      5'h12
`define BDALU_OP_DECIMAL_SUBTRACT_EXTENDED     5'h13
`define BDALU_OP_XOR      5'h14
`define BDALU_OP_IOR      5'h15
`define BDALU_OP_AND      5'h16
`define BDALU_OP_CMP      5'h17
// condition register bit positions
`define BDALU_CR_BIT      0
`define BDALU_CR_CARRY    1
`define BDALU_CR_OVF      2
`define BDALU_CR_DCARRY   3
`define BDALU_CR_SLT      4
`define BDALU_CR_SEQ      5
`define BDALU_CR_ULT      6
`define BDALU_CR_UEQ      7
`define BDALU_CR_W        8
`define BDALU_CR_RST      8'h00
`define BDALU_REG_RST     16'h0000
`endif

// ===== src/bdalu_core.v
// binary/decimal alu datapath with linked a and b feeder registers
`timescale 1ns/1ps
`include "bdalu_regs.vh"
module bdalu_core #(
	parameter W = 16
) (
	ref_clk,
	rst,
	alu_valid,
	alu_has_dest,
	alu_op,
	dest_field,
	dest_is_a,
	dest_is_b,
	cr_load,
	bus_in,
	bus_out,
	bus_oe,
	dest_enable,
	result_valid,
	busy,
	a_out,
	b_out,
	cr_out
);
	input  wire                ref_clk;
	input  wire                rst;
	input  wire                alu_valid;
	input  wire                alu_has_dest;
	input  wire [4:0]          alu_op;
	input  wire [4:0]          dest_field;
	input  wire                dest_is_a;
	input  wire                dest_is_b;
	input  wire                cr_load;
	input  wire [W-1:0]        bus_in;
	output reg  [W-1:0]        bus_out;
	output reg                 bus_oe;
	output reg                 dest_enable;
	output reg                 result_valid;
	output reg                 busy;
	output reg  [W-1:0]        a_out;
	output reg  [W-1:0]        b_out;
	output reg  [`BDALU_CR_W-1:0] cr_out;

	localparam ST_IDLE = 2'b01;
	localparam ST_DEC2 = 2'b10;

	reg [W-1:0]            a_q;
	reg [W-1:0]            b_q;
	reg [`BDALU_CR_W-1:0]  cr_q;
	reg [`BDALU_CR_W-1:0]  cr_d;
	reg [1:0]              st_q;
	reg [7:0]              dres_q;
	reg                    dcar_q;
	reg                    ddst_q;
	reg [W-1:0]            res;
	reg                    res_ok;
	reg [1:0]              mode_a;
	reg [1:0]              mode_b;
	reg [W:0]              sum;
	reg                    cin;
	reg                    is_sub;
	reg                    bt_bit;
	reg                    use_dec;
	reg                    dsub;
	reg                    dcin;
	reg [8:0]              dsum;
	wire [7:0]             dop_b;

	// one bcd digit add with correction above nine
	function [4:0] bcd_digit;
		input [3:0] x;
		input [3:0] y;
		input       c;
		reg   [4:0] s;
		reg   [4:0] adj;
		begin
			s   = {1'b0, x} + {1'b0, y} + {4'h0, c};
			// adding six skips the six unused codes and sets the digit carry
			adj = s + 5'h06;
			if (s > 5'h09)
				bcd_digit = {1'b1, adj[3:0]};
			else
				bcd_digit = s;
		end
	endfunction

	// nine's complement of a digit
	function [3:0] nines;
		input [3:0] d;
		begin
			nines = 4'h9 - d;
		end
	endfunction

	// one-bit end-off right shift of the a:b chain; the bit leaving b is lost
	function [2*W-1:0] chain_shr;
		input [2*W-1:0] c;
		begin
			chain_shr = {1'b0, c[2*W-1:1]};
		end
	endfunction

	// one-bit end-off left shift of the a:b chain; the bit leaving a is lost
	function [2*W-1:0] chain_shl;
		input [2*W-1:0] c;
		begin
			chain_shl = {c[2*W-2:0], 1'b0};
		end
	endfunction

	// one shifted copy feeds both the output and the feeders,
	// so the destination sees exactly what a holds after the edge
	wire [2*W-1:0] chain_r;
	wire [2*W-1:0] chain_l;
	assign chain_r = chain_shr({a_q, b_q});
	assign chain_l = chain_shl({a_q, b_q});

	assign dop_b = dsub ? {nines(b_q[7:4]), nines(b_q[3:0])} : b_q[7:0];

	// operation decode from the 5-bit op field, gated by alu_valid and the state; dest_field, dest_is_a and dest_is_b also feed it
	always @* begin
		res    = a_q;
		res_ok = 1'b1;
		mode_a = `BDALU_MODE_HOLD;
		mode_b = `BDALU_MODE_HOLD;
		cin    = 1'b0;
		is_sub = 1'b0;
		use_dec = 1'b0;
		dsub   = 1'b0;
		dcin   = 1'b0;
		cr_d   = cr_q;
		bt_bit = 1'b0;
		sum    = {1'b0, a_q} + {1'b0, b_q};
		dsum   = 9'h000;
		case (alu_op)
			`BDALU_OP_ADD, `BDALU_OP_BAD, `BDALU_OP_BINARY_ADD_WITH_CARRY,
			`BDALU_OP_SUB, `BDALU_OP_BSB, `BDALU_OP_BINARY_SUBTRACT_WITH_BORROW: begin
				is_sub = (alu_op == `BDALU_OP_SUB) || (alu_op == `BDALU_OP_BSB) || (alu_op == `BDALU_OP_BINARY_SUBTRACT_WITH_BORROW);
				// extended forms chain the stored carry for multi-word work
				if (alu_op == `BDALU_OP_BINARY_ADD_WITH_CARRY || alu_op == `BDALU_OP_BINARY_SUBTRACT_WITH_BORROW)
					cin = cr_q[`BDALU_CR_CARRY];
				else
					cin = is_sub;
				sum = {1'b0, a_q} + {1'b0, (is_sub ? ~b_q : b_q)} + {{W{1'b0}}, cin};
				res = sum[W-1:0];
				cr_d[`BDALU_CR_CARRY] = sum[W];
				cr_d[`BDALU_CR_OVF] = (a_q[W-1] == (is_sub ? ~b_q[W-1] : b_q[W-1])) && (sum[W-1] != a_q[W-1]);
			end
			`BDALU_OP_DAD, `BDALU_OP_DECIMAL_ADD_EXTENDED, `BDALU_OP_DSB, `BDALU_OP_DECIMAL_SUBTRACT_EXTENDED: begin
				use_dec = 1'b1;
				dsub = (alu_op == `BDALU_OP_DSB) || (alu_op == `BDALU_OP_DECIMAL_SUBTRACT_EXTENDED);
				if (alu_op == `BDALU_OP_DAD)
					dcin = 1'b0;
				else if (alu_op == `BDALU_OP_DSB)
					dcin = 1'b1;
				else
					dcin = cr_q[`BDALU_CR_DCARRY];
				res_ok = 1'b0;
			end
			`BDALU_OP_SHR: begin
				mode_a = `BDALU_MODE_RIGHT;
				mode_b = `BDALU_MODE_RIGHT;
				res = chain_r[2*W-1:W];
			end
			`BDALU_OP_SHL: begin
				mode_a = `BDALU_MODE_LEFT;
				mode_b = `BDALU_MODE_LEFT;
				res = chain_l[2*W-1:W];
			end
			`BDALU_OP_INS1: res = {b_q[W-1:4], a_q[3:0]};
			`BDALU_OP_INS2: res = {b_q[W-1:8], a_q[7:4], b_q[3:0]};
			`BDALU_OP_INSB: res = {b_q[W-1:8], a_q[7:0]};
			`BDALU_OP_PASS_A: res = a_q;
			`BDALU_OP_PASS_B: res = b_q;
			`BDALU_OP_INV: res = ~a_q;
			`BDALU_OP_BT_REG, `BDALU_OP_BT_FLD: begin
				if (alu_op == `BDALU_OP_BT_FLD)
					bt_bit = a_q[dest_field[3:0]];
				else
					bt_bit = a_q[b_q[3:0]];
				cr_d[`BDALU_CR_BIT] = bt_bit;
				res_ok = 1'b0;
			end
			`BDALU_OP_XOR: res = a_q ^ b_q;
			`BDALU_OP_IOR: res = a_q | b_q;
			`BDALU_OP_AND: res = a_q & b_q;
			`BDALU_OP_CMP: begin
				cr_d[`BDALU_CR_SLT] = $signed(a_q) < $signed(b_q);
				cr_d[`BDALU_CR_SEQ] = a_q == b_q;
				cr_d[`BDALU_CR_ULT] = a_q < b_q;
				cr_d[`BDALU_CR_UEQ] = a_q == b_q;
				res_ok = 1'b0;
			end
			default: res_ok = 1'b0;
		endcase
		// decimal adder sits beside the binary path, on low bytes only
		begin : dec_blk
			reg [4:0] lo;
			reg [4:0] hi;
			lo = bcd_digit(a_q[3:0], dop_b[3:0], dcin);
			hi = bcd_digit(a_q[7:4], dop_b[7:4], lo[4]);
			dsum = {hi[4], hi[3:0], lo[3:0]};
		end
		// bus load overrides hold; named destination always wins
		if (dest_is_a)
			mode_a = `BDALU_MODE_LOAD;
		if (dest_is_b)
			mode_b = `BDALU_MODE_LOAD;
		if (!alu_valid || st_q != ST_IDLE) begin
			mode_a = dest_is_a ? `BDALU_MODE_LOAD : `BDALU_MODE_HOLD;
			mode_b = dest_is_b ? `BDALU_MODE_LOAD : `BDALU_MODE_HOLD;
			cr_d = cr_q;
			use_dec = 1'b0;
			res_ok = 1'b0;
		end
	end

	// feeder registers, two 8-bit halves each, chained a:b for shifts
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			a_q <= `BDALU_REG_RST;
			b_q <= `BDALU_REG_RST;
		end else begin
			case (mode_a)
				`BDALU_MODE_RIGHT: a_q <= chain_r[2*W-1:W];
				`BDALU_MODE_LEFT:  a_q <= chain_l[2*W-1:W];
				`BDALU_MODE_LOAD:  a_q <= bus_in;
				default:           a_q <= a_q;
			endcase
			case (mode_b)
				`BDALU_MODE_RIGHT: b_q <= chain_r[W-1:0];
				`BDALU_MODE_LEFT:  b_q <= chain_l[W-1:0];
				`BDALU_MODE_LOAD:  b_q <= bus_in;
				default:           b_q <= b_q;
			endcase
		end
	end

	// decimal ops take a second cycle; result and carry land then
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_q   <= ST_IDLE;
			dres_q <= 8'h00;
			dcar_q <= 1'b0;
			ddst_q <= 1'b0;
			cr_q   <= `BDALU_CR_RST;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (use_dec) begin
						st_q   <= ST_DEC2;
						dres_q <= dsum[7:0];
						dcar_q <= dsum[8];
						// remember the format, the bus is only driven a cycle later
						ddst_q <= alu_has_dest;
					end
					// a bus load of the condition register wins over the alu's own update
					if (cr_load)
						cr_q <= bus_in[`BDALU_CR_W-1:0];
					else
						cr_q <= cr_d;
				end
				ST_DEC2: begin
					// ops offered in this cycle are dropped; only feeder loads go through
					st_q <= ST_IDLE;
					cr_q[`BDALU_CR_DCARRY] <= dcar_q;
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// registered outputs; drivers only for alu formats with a destination
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bus_out      <= `BDALU_REG_RST;
			bus_oe       <= 1'b0;
			dest_enable  <= 1'b0;
			result_valid <= 1'b0;
			busy         <= 1'b0;
			a_out        <= `BDALU_REG_RST;
			b_out        <= `BDALU_REG_RST;
			cr_out       <= `BDALU_CR_RST;
		end else begin
			if (st_q == ST_DEC2) begin
				bus_out      <= {{(W-8){1'b0}}, dres_q};
				// a decimal op without a destination still runs but never drives the bus
				bus_oe       <= ddst_q;
				dest_enable  <= ddst_q;
				result_valid <= ddst_q;
			end else begin
				bus_out      <= res;
				bus_oe       <= res_ok && alu_has_dest;
				dest_enable  <= res_ok && alu_has_dest;
				result_valid <= res_ok && alu_has_dest;
			end
			busy   <= use_dec;
			a_out  <= a_q;
			b_out  <= b_q;
			cr_out <= cr_q;
		end
	end
endmodule

// ===== bench/bdalu_core_chk.sv
// port-level assertions for the binary/decimal alu datapath
`timescale 1ns/1ps
`include "bdalu_regs.vh"
module bdalu_core_chk #(
	parameter W = 16
) (
	input wire                    ref_clk,
	input wire                    rst,
	input wire                    alu_valid,
	input wire                    alu_has_dest,
	input wire [4:0]              alu_op,
	input wire [W-1:0]            bus_out,
	input wire                    bus_oe,
	input wire                    dest_enable,
	input wire                    result_valid,
	input wire                    busy,
	input wire [`BDALU_CR_W-1:0]  cr_out
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// an op counts as taken only when no decimal op from the cycle before holds this cycle
	wire tk  = alu_valid && !busy;
	wire dst = tk && alu_has_dest;
	wire dec = alu_op >= `BDALU_OP_DAD && alu_op <= `BDALU_OP_DECIMAL_SUBTRACT_EXTENDED;
	wire bin = alu_op >= `BDALU_OP_ADD && alu_op <= `BDALU_OP_BINARY_SUBTRACT_WITH_BORROW;
	wire lgc = alu_op >= `BDALU_OP_XOR && alu_op <= `BDALU_OP_AND;
	AST_BT_NODRV: assert property (tk && (alu_op == `BDALU_OP_BT_REG || alu_op == `BDALU_OP_BT_FLD) |=> !bus_oe)
		else $error("bit test drove the bus");
	AST_NODEST: assert property (tk && !alu_has_dest |=> !bus_oe)
		else $error("bus driven without destination");
	AST_OE_DEST: assert property (dest_enable == bus_oe)
		else $error("dest enable differs from bus enable");
	AST_BIN_ONE: assert property (dst && bin |=> bus_oe && result_valid)
		else $error("binary result late");
	AST_DEC_TWO: assert property (dst && dec |=> busy && !bus_oe ##1 bus_oe && bus_out[15:8] == 8'h00)
		else $error("decimal result timing or width wrong");
	AST_BUSY_ONE: assert property ($rose(busy) |=> !busy)
		else $error("busy held too long");
	AST_LOGIC: assert property (dst && lgc |=> bus_oe && result_valid)
		else $error("logic result missing");
	AST_CMP: assert property (tk && alu_op == `BDALU_OP_CMP |=> !bus_oe ##1
		(cr_out[5] == cr_out[7]) && !(cr_out[5] && (cr_out[4] || cr_out[6])))
		else $error("compare flags inconsistent");
	// main scenarios seen at the ports
	CV_DEC: cover property (dst && dec);
	CV_CMP: cover property (tk && alu_op == `BDALU_OP_CMP);
	CV_BIN: cover property (dst && bin ##1 dst);
endmodule
bind bdalu_core bdalu_core_chk #(.W(W)) bdalu_core_chk_inst (.ref_clk(ref_clk), .rst(rst),
	.alu_valid(alu_valid), .alu_has_dest(alu_has_dest), .alu_op(alu_op), .bus_out(bus_out),
	.bus_oe(bus_oe), .dest_enable(dest_enable), .result_valid(result_valid), .busy(busy), .cr_out(cr_out));

// ===== bench/bdalu_udec.sv
// micro-instruction source and bus model feeding the alu
`timescale 1ns/1ps
module bdalu_udec (
	input wire          ref_clk,
	output logic        alu_valid,
	output logic        alu_has_dest,
	output logic [4:0]  alu_op,
	output logic [4:0]  dest_field,
	output logic        dest_is_a,
	output logic        dest_is_b,
	output logic        cr_load,
	output logic [15:0] bus_in
);
	initial begin
		{alu_valid, alu_has_dest, alu_op, dest_field, dest_is_a, dest_is_b, cr_load} = 15'h0000;
		bus_in = 16'h0000;
	end
	// one micro-instruction per cycle; an unloaded bus flips so stale data never passes as valid
	task issue(input [4:0] op, input v, input da, input db, input [15:0] d);
		@(posedge ref_clk);
		alu_valid <= v;
		alu_has_dest <= v;
		alu_op <= op;
		dest_field <= 5'h02;
		dest_is_a <= da;
		dest_is_b <= db;
		bus_in <= (da || db) ? d : ~bus_in;
	endtask
endmodule

// ===== bench/test_binary_decimal_alu_with_feeders.sv
// self-checking bench for the binary/decimal alu datapath
`timescale 1ns/1ps
`include "bdalu_regs.vh"
module test_binary_decimal_alu_with_feeders;
	logic        ref_clk, rst, alu_valid, alu_has_dest, dest_is_a, dest_is_b, cr_load;
	logic        bus_oe, dest_enable, result_valid, busy;
	logic [4:0]  alu_op, dest_field;
	logic [15:0] bus_in, bus_out, a_out, b_out;
	logic [7:0]  cr_out;
	int          mismatches = 0;
	int          samples_checked = 0;
	bdalu_udec bdalu_udec_inst (.*);
	bdalu_core #(.W(16)) bdalu_core_inst (.*);
	task final_report;
		if (mismatches == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk_word(input [15:0] g, input [15:0] e);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// load a then b, run one op, then read the bus and the condition bits once they settle
	task t(input [15:0] a, input [15:0] b, input [4:0] op, input [15:0] e, input [7:0] c);
		logic       dec, nod;
		logic [7:0] m;
		dec = op >= `BDALU_OP_DAD && op <= `BDALU_OP_DECIMAL_SUBTRACT_EXTENDED;
		nod = op == `BDALU_OP_BT_REG || op == `BDALU_OP_BT_FLD || op == `BDALU_OP_CMP;
		m = dec ? 8'h08 : (op == `BDALU_OP_CMP) ? 8'hf0 : nod ? 8'h01 :
			(op >= `BDALU_OP_ADD && op <= `BDALU_OP_BINARY_SUBTRACT_WITH_BORROW) ? 8'h06 : 8'h00;
		bdalu_udec_inst.issue(5'h00, 1'b0, 1'b1, 1'b0, a);
		bdalu_udec_inst.issue(5'h00, 1'b0, 1'b0, 1'b1, b);
		bdalu_udec_inst.issue(op, 1'b1, 1'b0, 1'b0, 16'h0000);
		bdalu_udec_inst.issue(5'h00, 1'b0, 1'b0, 1'b0, 16'h0000);
		if (dec)
			@(posedge ref_clk);
		#1;
		chk_word({15'h0000, bus_oe}, {15'h0000, !nod});
		if (!nod)
			chk_word(bus_out, e);
		repeat (3) @(posedge ref_clk);
		#1 chk_word({8'h00, cr_out & m}, {8'h00, c});
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	// hang guard, well past the roughly 150 cycles the sequence needs
	initial begin
		repeat (3000) @(posedge ref_clk);
		mismatches++;
		final_report;
	end
	initial begin
		rst = 1'b1;
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		t(16'h1234, 16'h5678, `BDALU_OP_PASS_A, 16'h1234, 8'h00);
		t(16'h1234, 16'h5678, `BDALU_OP_PASS_B, 16'h5678, 8'h00);
		t(16'h1234, 16'h5678, `BDALU_OP_INV, 16'hedcb, 8'h00);
		t(16'h1234, 16'h5678, `BDALU_OP_INS1, 16'h5674, 8'h00);
		t(16'h1234, 16'h5678, `BDALU_OP_INS2, 16'h5638, 8'h00);
		t(16'h1234, 16'h5678, `BDALU_OP_INSB, 16'h5634, 8'h00);
		t(16'h1234, 16'h5678, `BDALU_OP_XOR, 16'h444c, 8'h00);
		t(16'h1234, 16'h5678, `BDALU_OP_IOR, 16'h567c, 8'h00);
		t(16'h1234, 16'h5678, `BDALU_OP_AND, 16'h1230, 8'h00);
		t(16'h1235, 16'h5678, `BDALU_OP_SHR, 16'h091a, 8'h00);
		chk_word(a_out, 16'h091a);
		chk_word(b_out, 16'hab3c);
		t(16'h1234, 16'h8678, `BDALU_OP_SHL, 16'h2469, 8'h00);
		chk_word(a_out, 16'h2469);
		chk_word(b_out, 16'h0cf0);
		t(16'hffff, 16'h0001, `BDALU_OP_ADD, 16'h0000, 8'h02);
		t(16'h0000, 16'h0000, `BDALU_OP_BINARY_ADD_WITH_CARRY, 16'h0001, 8'h00);
		t(16'h8000, 16'h0001, `BDALU_OP_SUB, 16'h7fff, 8'h06);
		t(16'h0004, 16'h0013, `BDALU_OP_BT_FLD, 16'h0000, 8'h01);
		t(16'h0004, 16'h0013, `BDALU_OP_BT_REG, 16'h0000, 8'h00);
		t(16'h1258, 16'h3467, `BDALU_OP_DAD, 16'h0025, 8'h08);
		t(16'h0001, 16'h0000, `BDALU_OP_DECIMAL_ADD_EXTENDED, 16'h0002, 8'h00);
		t(16'h0025, 16'h0058, `BDALU_OP_DSB, 16'h0067, 8'h00);
		t(16'h8000, 16'h0001, `BDALU_OP_CMP, 16'h0000, 8'h10);
		final_report;
	end
endmodule
